// ---- logic/gate_seq_pkg.sv ----
package gate_seq_pkg;
  localparam int DLY_W = 8;
  localparam int LVL_W = 4;

  // Register byte addresses
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] REG_OFF_OFS = 8'h04;
  localparam logic [7:0] SAFE_OFS    = 8'h08;
  localparam logic [7:0] ON_OFS      = 8'h0C;
  localparam logic [7:0] STAT_OFS    = 8'h10;

  // Field positions
  localparam int FILT_BIT     = 0;
  localparam int OFF_COMP_BIT = 1;
  localparam int ON_COMP_BIT  = 2;
  localparam int DLY_LSB      = 0;
  localparam int LVL_LSB      = 8;
  localparam int STAT_ST_LSB  = 0;
  localparam int STAT_SAFE    = 4;

  // Reset values and the minimum turn-on hold
  localparam logic [DLY_W-1:0] DLY_RST = 8'h00;
  localparam logic [LVL_W-1:0] LVL_RST = 4'h0;
  localparam logic [DLY_W-1:0] MIN_ON_TICKS = 8'h02;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_WAIT,
    ST_ON_PLAT,
    ST_ON_FULL,
    ST_OFF_PLAT
  } seq_state_t;
endpackage

// ---- logic/gate_switch_sequencer.sv ----
module gate_switch_sequencer (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       pwm_input_i,
  input  wire logic                       desaturation_event_i,
  input  wire logic                       overcurrent_event_i,
  input  wire logic                       start_stop_osc_i,
  input  wire logic                       main_secondary_osc_i,
  output logic                            gate_source_out_o,
  output logic                            gate_sink_out_o,
  output logic                            plateau_o,
  output logic [gate_seq_pkg::LVL_W-1:0]  plateau_level_o,
  output logic                            level_comp_o,
  output logic                            safe_off_o
);
  import gate_seq_pkg::*;

  typedef struct packed {
    seq_state_t       st;
    logic             safe;
    logic [DLY_W-1:0] dly;
    logic             ack;
    logic [31:0]      rdat;
    logic             filt;
    logic             off_comp;
    logic             on_comp;
    logic [DLY_W-1:0] reg_dly;
    logic [DLY_W-1:0] safe_dly;
    logic [DLY_W-1:0] on_dly;
    logic [LVL_W-1:0] reg_lvl;
    logic [LVL_W-1:0] safe_lvl;
    logic [LVL_W-1:0] on_lvl;
    logic             src;
    logic             snk;
    logic             plat;
    logic [LVL_W-1:0] lvl;
    logic             comp;
    logic             load;
    logic [DLY_W-1:0] load_val;
    logic             ticksel;
  } state_t;

  state_t q;
  state_t next_q;
  logic   t_done;
  logic   tick;
  logic   safe_evt;

  assign safe_evt = desaturation_event_i | overcurrent_event_i;
  // One timer serves every phase; a safe turn-off ticks on the main oscillator, all else on start-stop
  assign tick = q.ticksel ? main_secondary_osc_i
                          : start_stop_osc_i;

  tick_timer #(
    .W (DLY_W)
  ) u_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .load_i   (q.load),
    .value_i  (q.load_val),
    .tick_i   (tick),
    .done_o   (t_done)
  );

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] pack_fields(
      input logic [DLY_W-1:0] d, input logic [LVL_W-1:0] l);
    logic [31:0] r;
    r = '0;
    r[DLY_LSB +: DLY_W] = d;
    r[LVL_LSB +: LVL_W] = l;
    return r;
  endfunction

  // Start of any turn-off; parameters are latched here for the
  // whole sequence so later writes cannot disturb it
  // Config comes from the registered copy c, so a bus write in the
  // same cycle cannot split the parameters of one sequence
  function automatic state_t off_start(input state_t s,
                                       input state_t c,
                                       input logic   safe);
    state_t r;
    logic [DLY_W-1:0] d;
    r = s;
    d = safe ? c.safe_dly : c.reg_dly;
    r.safe = safe;
    r.dly = d;
    r.ticksel = safe;
    r.src = 1'b0;
    r.snk = 1'b1;
    r.comp = c.off_comp;
    if (d == '0) begin
      r.st = ST_OFF;
      r.plat = 1'b0;
    end else begin
      r.st = ST_OFF_PLAT;
      r.plat = 1'b1;
      r.lvl = safe ? c.safe_lvl : c.reg_lvl;
      r.load = 1'b1;
      r.load_val = d;
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] wr;
    logic [31:0] rd;
    wr = '0;
    rd = '0;
    next_q = q;
    next_q.load = 1'b0;
    next_q.ack = 1'b0;

    // Wishbone slave: one wait state, unmapped reads give zero
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      next_q.ack = 1'b1;
      unique case (wb_adr_i)
        CTRL_OFS: begin
          rd[FILT_BIT] = q.filt;
          rd[OFF_COMP_BIT] = q.off_comp;
          rd[ON_COMP_BIT] = q.on_comp;
        end
        REG_OFF_OFS: rd = pack_fields(q.reg_dly, q.reg_lvl);
        SAFE_OFS:    rd = pack_fields(q.safe_dly, q.safe_lvl);
        ON_OFS:      rd = pack_fields(q.on_dly, q.on_lvl);
        STAT_OFS: begin
          rd[STAT_ST_LSB +: 3] = q.st;
          rd[STAT_SAFE] = q.safe;
        end
        default: rd = '0;
      endcase
      next_q.rdat = wb_we_i ? '0 : rd;
      if (wb_we_i) begin
        wr = merge(rd, wb_dat_i, wb_sel_i);
        unique case (wb_adr_i)
          CTRL_OFS: begin
            next_q.filt = wr[FILT_BIT];
            next_q.off_comp = wr[OFF_COMP_BIT];
            next_q.on_comp = wr[ON_COMP_BIT];
          end
          REG_OFF_OFS: begin
            next_q.reg_dly = wr[DLY_LSB +: DLY_W];
            next_q.reg_lvl = wr[LVL_LSB +: LVL_W];
          end
          SAFE_OFS: begin
            next_q.safe_dly = wr[DLY_LSB +: DLY_W];
            next_q.safe_lvl = wr[LVL_LSB +: LVL_W];
          end
          ON_OFS: begin
            next_q.on_dly = wr[DLY_LSB +: DLY_W];
            next_q.on_lvl = wr[LVL_LSB +: LVL_W];
          end
          default: ;
        endcase
      end
    end

    // Switching sequencer
    unique case (q.st)
      ST_OFF: begin
        if (pwm_input_i && !safe_evt) begin
          next_q.st = ST_ON_WAIT;
          next_q.safe = 1'b0;
          next_q.ticksel = 1'b0;
          next_q.dly = q.reg_dly;
          next_q.load = 1'b1;
          next_q.load_val = q.reg_dly;
        end
      end
      ST_ON_WAIT: begin
        if (safe_evt) begin
          next_q.st = ST_OFF;
        end else if (q.filt && start_stop_osc_i
                     && !pwm_input_i) begin
          next_q.st = ST_OFF;
        end else if (q.dly == '0 || t_done) begin
          // Source rises now; hold at least two ticks so a short
          // command still yields on_dly ticks, or two ticks if on_dly is shorter
          next_q.st = ST_ON_PLAT;
          next_q.src = 1'b1;
          next_q.snk = 1'b0;
          next_q.plat = (q.on_dly != '0);
          next_q.comp = q.on_comp;
          next_q.lvl = q.on_lvl;
          next_q.load = 1'b1;
          next_q.load_val = (q.on_dly > MIN_ON_TICKS) ? q.on_dly
                                                     : MIN_ON_TICKS;
        end
      end
      ST_ON_PLAT: begin
        next_q.lvl = q.on_lvl;
        next_q.comp = q.on_comp;
        if (safe_evt) begin
          next_q = off_start(next_q, q, 1'b1);
        end else if (t_done) begin
          next_q.st = ST_ON_FULL;
          next_q.plat = 1'b0;
        end
      end
      ST_ON_FULL: begin
        if (safe_evt) begin
          next_q = off_start(next_q, q, 1'b1);
        end else if (!pwm_input_i) begin
          next_q = off_start(next_q, q, 1'b0);
        end
      end
      ST_OFF_PLAT: begin
        if (t_done) begin
          next_q.st = ST_OFF;
          next_q.plat = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{st: ST_OFF, snk: 1'b1, reg_dly: DLY_RST,
             safe_dly: DLY_RST, on_dly: DLY_RST, reg_lvl: LVL_RST,
             safe_lvl: LVL_RST, on_lvl: LVL_RST, default: '0};
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign gate_source_out_o = q.src;
  assign gate_sink_out_o = q.snk;
  assign plateau_o = q.plat;
  assign plateau_level_o = q.lvl;
  assign level_comp_o = q.comp;
  assign safe_off_o = q.safe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_SAFE_CAUSE: assert property (
    $rose(q.st == ST_OFF_PLAT) && q.safe |-> $past(safe_evt))
    else $error("safe turn-off without triggering event");

  AST_REGULAR_PARAMS: assert property (
    q.st == ST_ON_FULL && !pwm_input_i && !safe_evt
      && q.reg_dly != '0
    |=> q.st == ST_OFF_PLAT && !q.safe && q.lvl == $past(q.reg_lvl)
        && q.dly == $past(q.reg_dly))
    else $error("regular turn-off used wrong parameters");

  AST_OFF_PLATEAU: assert property (
    q.st == ST_OFF_PLAT |-> q.snk && q.plat && !q.src)
    else $error("turn-off plateau outputs wrong");

  AST_REG_SKIP: assert property (
    q.st == ST_ON_FULL && !pwm_input_i && !safe_evt
      && q.reg_dly == '0
    |=> q.st == ST_OFF && !q.plat && q.snk)
    else $error("zero regular delay did not skip plateau");

  AST_SAFE_SKIP: assert property (
    q.st == ST_ON_FULL && safe_evt && q.safe_dly == '0
    |=> q.st == ST_OFF && !q.plat && q.safe)
    else $error("zero safe delay did not skip plateau");

  AST_TICK_SOURCE: assert property (
    q.st == ST_OFF_PLAT |-> q.ticksel == q.safe)
    else $error("turn-off timed on wrong oscillator");

  AST_FILTER_ABORT: assert property (
    q.st == ST_ON_WAIT && q.filt && start_stop_osc_i
      && !pwm_input_i
    |=> q.st == ST_OFF && !q.src ##1 !q.src)
    else $error("filter did not abort turn-on");

  AST_NO_FILTER: assert property (
    q.st == ST_ON_WAIT && !q.filt && !safe_evt
    |=> q.st != ST_OFF)
    else $error("turn-on aborted with filter disabled");

  AST_ON_PLATEAU: assert property (
    $rose(q.st == ST_ON_PLAT) |-> q.src && !q.snk
      && q.plat == ($past(q.on_dly) != '0))
    else $error("turn-on plateau selection wrong");

  AST_OFF_COMPLETES: assert property (
    q.st == ST_OFF_PLAT |=> q.st inside {ST_OFF_PLAT, ST_OFF}
      && $stable(q.dly))
    else $error("turn-off sequence interrupted");

  AST_WB_ACK: assert property (
    wb_cyc_i && wb_stb_i && !q.ack |=> q.ack ##1 !q.ack)
    else $error("bus acknowledge timing wrong");

  AST_ON_LEVEL_TRACK: assert property (
    q.st == ST_ON_PLAT && $past(q.st) == ST_ON_PLAT
    |-> q.lvl == $past(q.on_lvl))
    else $error("turn-on level update not applied");

  AST_OFF_COMP: assert property (
    $rose(q.snk) |-> q.comp == $past(q.off_comp))
    else $error("turn-off compensation select wrong");

  AST_ON_COMP: assert property (
    $rose(q.src) |-> q.comp == $past(q.on_comp))
    else $error("turn-on compensation select wrong");

  AST_ON_STRETCH: assert property (
    q.st == ST_ON_PLAT && !safe_evt && !t_done |=> q.st == ST_ON_PLAT)
    else $error("turn-on hold ended early");

  AST_SAFE_OVERRIDES_ON: assert property (
    q.st inside {ST_ON_PLAT, ST_ON_FULL} && safe_evt
    |=> q.snk && !q.src && q.safe)
    else $error("safe event did not end turn-on");

  AST_OFF_UNFILTERED: assert property (
    q.st == ST_ON_FULL && !pwm_input_i |=> q.snk && !q.src)
    else $error("turn-off command not obeyed");

  AST_ON_DELAY_LATCH: assert property (
    $rose(q.st == ST_ON_WAIT) |-> q.dly == $past(q.reg_dly))
    else $error("turn-on delay not latched");

  AST_DRIVE_EXCLUSIVE: assert property (
    !(q.src && q.snk))
    else $error("source and sink driven together");
endmodule // gate_switch_sequencer

// ---- logic/tick_timer.sv ----
module tick_timer #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         tick_i,
  output logic              done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } tmr_t;

  tmr_t q;
  tmr_t next_q;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (load_i) begin
      next_q.cnt = value_i;
    end else if (tick_i && q.cnt != '0) begin
      next_q.cnt = q.cnt - 1'b1;
      next_q.done = (q.cnt == W'(1));
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done_o = q.done;
endmodule // tick_timer

// ---- testbench/gate_booster_model.sv ----
module gate_booster_model (
  input  wire logic       source_i,
  input  wire logic       sink_i,
  input  wire logic       plateau_i,
  output logic      [1:0] gate_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Gate mode: 0 hard off, 1 plateau, 2 full on
  // Plateau wins, the booster holds the clamp level whichever way it goes
  always_comb begin
    if (plateau_i) begin
      gate_mode_o = 2'h1;
    end else if (source_i && !sink_i) begin
      gate_mode_o = 2'h2;
    end else begin
      gate_mode_o = 2'h0;
    end
  end
endmodule // gate_booster_model

// ---- testbench/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gate_seq_pkg::*;
  logic        clk_i, resetn_i, cyc, stb, we, pwm, desaturation_event, overcurrent_event, ss, ms;
  logic        src, snk, plat, comp, safe, ack;
  logic [7:0]  adr;
  logic [3:0]  lvl, sel, lanes;
  logic [31:0] dat_w, dat_r, q;
  logic [1:0]  gate_mode, cnt;
  int          errors, checked, n;

  gate_switch_sequencer u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .pwm_input_i(pwm), .desaturation_event_i(desaturation_event),
    .overcurrent_event_i(overcurrent_event), .start_stop_osc_i(ss),
    .main_secondary_osc_i(ms), .gate_source_out_o(src),
    .gate_sink_out_o(snk), .plateau_o(plat), .plateau_level_o(lvl),
    .level_comp_o(comp), .safe_off_o(safe));
  gate_booster_model u_gate (.source_i(src), .sink_i(snk),
    .plateau_i(plat), .gate_mode_o(gate_mode));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Start-stop tick every 4 clocks, main tick every 2
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt <= 2'h0;
      ss  <= 1'b0;
      ms  <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      ss  <= (cnt == 2'h3);
      ms  <= cnt[0];
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= lanes;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // Read data stands at the edge where ack is sampled high
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
  endtask

  function automatic logic pick(input int k);
    return (k == 0) ? src : (k == 1) ? snk : plat;
  endfunction

  // Bounded wait for source (0), sink (1) or plateau (2) to reach v
  task automatic wait_for(input int k, input logic v);
    n = 0;
    while (pick(k) !== v && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 300) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic drive_pwm(input logic v);
    @(posedge clk_i);
    pwm <= v;
  endtask

  initial begin
    resetn_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    pwm = 1'b0;
    desaturation_event = 1'b0;
    overcurrent_event = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    lanes = 4'hF;
    dat_w = 32'h0000_0000;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk("sink in reset", 1, snk);
    wb(0, CTRL_OFS, 0);
    chk("ctrl reset", 0, q);
    wb(1, 8'h20, 32'h0000_FFFF);
    wb(0, 8'h20, 0);
    chk("unmapped", 0, q);
    lanes = 4'h2;
    wb(1, REG_OFF_OFS, 32'h0000_0A33);
    lanes = 4'hF;
    wb(0, REG_OFF_OFS, 0);
    chk("byte lanes", 32'h0000_0A00, q);
    $display("test reset done");
    wb(1, REG_OFF_OFS, 32'h0000_0503);
    wb(1, ON_OFS, 32'h0000_0702);
    wb(1, CTRL_OFS, 32'h0000_0006);
    drive_pwm(1);
    wait_for(0, 1);
    chk("on plateau", 1, plat);
    chk("on level", 7, lvl);
    chk("on comp", 1, comp);
    wb(1, ON_OFS, 32'h0000_0802);
    @(negedge clk_i);
    chk("on level update", 8, lvl);
    wait_for(2, 0);
    chk("gate full", 2, gate_mode);
    drive_pwm(0);
    wait_for(1, 1);
    chk("off plateau", 1, plat);
    chk("off level", 5, lvl);
    chk("off comp", 1, comp);
    chk("regular", 0, safe);
    wait_for(2, 0);
    $display("test regular done");
    wb(1, SAFE_OFS, 32'h0000_0902);
    for (int e = 0; e < 2; e++) begin
      drive_pwm(1);
      wait_for(0, 1);
      wait_for(2, 0);
      @(posedge clk_i);
      desaturation_event <= (e == 0);
      overcurrent_event <= (e == 1);
      wait_for(1, 1);
      chk("safe flag", 1, safe);
      chk("safe level", 9, lvl);
      @(posedge clk_i);
      desaturation_event <= 1'b0;
      overcurrent_event   <= 1'b0;
      pwm   <= 1'b0;
      wait_for(2, 0);
      // Two main ticks plus load and exit edges; start-stop is longer
      chk("safe timing", 1, n >= 5 && n <= 6);
      repeat (4) @(posedge clk_i);
    end
    $display("test safe done");
    wb(1, REG_OFF_OFS, 32'h0000_0500);
    drive_pwm(1);
    wait_for(0, 1);
    wait_for(2, 0);
    drive_pwm(0);
    wait_for(1, 1);
    chk("no plateau", 0, plat);
    $display("test zero delay done");
    wb(1, REG_OFF_OFS, 32'h0000_0504);
    wb(1, CTRL_OFS, 32'h0000_0001);
    drive_pwm(1);
    drive_pwm(1);
    drive_pwm(0);
    repeat (40) begin
      @(negedge clk_i);
      chk("suppressed", 0, src);
    end
    drive_pwm(1);
    wait_for(0, 1);
    wait_for(2, 0);
    drive_pwm(0);
    wait_for(1, 1);
    chk("filtered off", 1, plat);
    $display("test filter done");
    report_and_stop();
  end
endmodule // tb
